//--- rtl/mic_pkg.sv
// Constants shared by the interrupt controller: register map, source table, timing.
// Assumes a core on the same clock and AXI4-Lite software access with 32-bit data.
//
// What this block does
// - Reset has top priority at vector 0; pin interrupt vector 2, pin-change vector 4.
// - Timer-clock 6, voltage detect 8, comparator 2 E, conversion 10, timer 1 12.
// - PWM A period/duty at 14/16; I2C transmit, receive, stop at 1A/1C/1E.
// - PWM B period/duty at 24/26; PWM C period/duty at 2A/2C.
// - Flags live in status indexes 14h to 16h, masks in indexes 1Bh to 1Dh.
// - Enable instruction sets the global enable, disable instruction clears it.
// - An enabled pending source redirects the next fetch to its own vector.
// - Flags set on their event regardless of mask or global enable, except pin change.
// - Return instruction ends service and sets the global enable like the enable instruction.
// - With the noise option 0, external pulses shorter than four clocks are discarded.
// - Low-frequency crystal mode bypasses the external noise filter completely.
// - External interrupt fires on a falling edge and fetches from address 003H.
// - Accumulator and registers 3 and 4 are saved on entry and restored on exit.
// - One backup only; a nested entry overwrites the saved context.
// - Every return stack entry is cleared to zero on any reset.
// - Wake enable bit 4 at 0x10, conversion flag bit 4 at 0x15, mask bit 4 at 0x1B.
// - Conversion done in sleep with mask set wakes; vectors only if globally enabled.
package mic_pkg;

  localparam int NUM_SRC = 16;
  localparam int VEC_W = 12;

  // ************************************************************
  // Register indexes; byte address is four times the index.
  // ************************************************************
  localparam logic [5:0] IDX_WAKEUP_CONTROL_2 = 6'h10;
  localparam logic [5:0] IDX_CONTROL = 6'h11;
  localparam logic [5:0] IDX_STATUS_0 = 6'h14;
  localparam logic [5:0] IDX_INTERRUPT_STATUS_1 = 6'h15;
  localparam logic [5:0] IDX_STATUS_2 = 6'h16;
  // The conversion group's masks sit at 1Bh, so the first status group's masks follow at 1Ch.
  localparam logic [5:0] IDX_MASK_0 = 6'h1C;
  localparam logic [5:0] IDX_INTERRUPT_MASK_1 = 6'h1B;
  localparam logic [5:0] IDX_MASK_2 = 6'h1D;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int WAKE_ADC_BIT = 4;
  localparam int CTL_DETECTOR_BIT = 0;
  localparam int CTL_NOISE_BIT = 1;
  localparam int CTL_LXT_BIT = 2;
  localparam int CTL_GIE_BIT = 7;

  // ************************************************************
  // Source table: index is priority minus one.
  // ************************************************************
  localparam int SRC_EXT = 0;
  localparam int SRC_PIN_CHANGE = 1;
  localparam int SRC_LVD = 3;
  localparam int SRC_ADC = 5;
  localparam logic [VEC_W-1:0] VEC_RESET = 12'h000;
  localparam logic [VEC_W-1:0] VEC_EXT_FETCH = 12'h003;
  localparam logic [NUM_SRC*VEC_W-1:0] SRC_VECTOR = {
    12'h02C, 12'h02A, 12'h026, 12'h024, 12'h01E, 12'h01C, 12'h01A, 12'h016,
    12'h014, 12'h012, 12'h010, 12'h00E, 12'h008, 12'h006, 12'h004, 12'h002};
  // Status register, relative to status 0, holding each source flag.
  localparam logic [NUM_SRC*2-1:0] SRC_REG = {
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1,
    2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  localparam logic [NUM_SRC*3-1:0] SRC_BIT = {
    3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h2,
    3'h1, 3'h0, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  // ************************************************************
  // Timing and protocol.
  // ************************************************************
  localparam int NOISE_REJECT_CLOCKS = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_REQ = 2'b01,
    SVC_BUSY = 2'b10
  } mic_svc_t;

endpackage

//--- rtl/mic_interrupt_controller.sv
// Interrupt controller: flags, masks, global enable, priority, vectoring, context, stack.
// Assumes core strobes and peripheral events on aclk; the external pin is asynchronous.
//
// The implementer's own choice: the AXI4-Lite register port.
module mic_interrupt_controller #(
  parameter int STACK_DEPTH = 8,
  parameter int DATA_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_int_pin,
  input wire logic [mic_pkg::NUM_SRC-1:1] src_event,
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic sleep_mode,
  input wire logic irq_accept,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] r3_in,
  input wire logic [DATA_W-1:0] r4_in,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [mic_pkg::VEC_W-1:0] push_addr,
  output logic irq_request,
  output logic [mic_pkg::VEC_W-1:0] irq_vector,
  output logic in_service,
  output logic [DATA_W-1:0] acc_saved,
  output logic [DATA_W-1:0] r3_saved,
  output logic [DATA_W-1:0] r4_saved,
  output logic restore_strobe,
  output logic wake_core,
  output logic [mic_pkg::VEC_W-1:0] stack_top
);
  import mic_pkg::*;

  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] mask;
  logic [NUM_SRC-1:0] event_in;
  logic [NUM_SRC-1:0] enabled_pending;
  logic gie;
  logic conversion_wakeup_enable;
  logic voltage_detector_enable;
  logic noise_reject_option;
  logic low_freq_crystal_mode;
  logic [7:0] status_reg [3];
  logic [7:0] mask_reg [3];
  logic pin_meta;
  logic pin_sync;
  logic pin_filt;
  logic pin_prev;
  logic [2:0] stable_cnt;
  logic pin_clean;
  mic_svc_t svc;
  mic_svc_t next_svc;
  logic any_pending;
  logic [VEC_W-1:0] next_vector;
  logic [VEC_W-1:0] stk [STACK_DEPTH];
  logic [7:0] wr_addr;
  logic aw_held;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic w_held;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;

  // ************************************************************
  // External pin: synchroniser, noise filter, falling edge.
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= ext_int_pin;
      pin_sync <= pin_meta;
    end
  end

  // A level must hold four clocks before the filter passes it on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_cnt <= 3'h0;
      pin_filt <= 1'b1;
    end else if (pin_sync == pin_filt) begin
      stable_cnt <= 3'h0;
    end else if (stable_cnt == 3'(NOISE_REJECT_CLOCKS - 1)) begin
      stable_cnt <= 3'h0;
      pin_filt <= pin_sync;
    end else begin
      stable_cnt <= stable_cnt + 3'h1;
    end
  end

  // The filter only runs with option 0 and outside low-frequency crystal mode.
  assign pin_clean = (noise_reject_option || low_freq_crystal_mode) ? pin_sync : pin_filt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= pin_clean;
    end
  end

  // ************************************************************
  // Flags, masks and the AXI write path.
  // ************************************************************
  assign event_in[SRC_EXT] = pin_prev && !pin_clean;
  assign event_in[NUM_SRC-1:1] = src_event;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = wr_addr[7:2];
  assign wr_hit = (wr_idx == IDX_WAKEUP_CONTROL_2) || (wr_idx == IDX_CONTROL) ||
    (wr_idx >= IDX_STATUS_0 && wr_idx <= IDX_STATUS_2) ||
    (wr_idx >= IDX_INTERRUPT_MASK_1 && wr_idx <= IDX_MASK_2);

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      localparam logic [1:0] RI = SRC_REG[i*2 +: 2];
      localparam int BI = int'(SRC_BIT[i*3 +: 3]);
      localparam logic [5:0] MI = (RI == 2'h0) ? IDX_MASK_0 :
        (RI == 2'h1) ? IDX_INTERRUPT_MASK_1 : IDX_MASK_2;
      logic wr_flag;
      logic wr_mask;
      assign wr_flag = wr_fire && wr_strb[0] && (wr_idx == IDX_STATUS_0 + 6'(RI));
      assign wr_mask = wr_fire && wr_strb[0] && (wr_idx == MI);
      // An event in the same cycle as a software clear wins.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag[i] <= 1'b0;
        end else if (event_in[i] && (i != SRC_PIN_CHANGE || mask[i])) begin
          flag[i] <= 1'b1;
        end else if (wr_flag) begin
          flag[i] <= wr_data[BI];
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mask[i] <= 1'b0;
        end else if (wr_mask) begin
          mask[i] <= wr_data[BI];
        end
      end
      if (i == SRC_LVD) begin : g_lvd
        assign enabled_pending[i] = flag[i] && mask[i] && voltage_detector_enable;
      end else begin : g_plain
        assign enabled_pending[i] = flag[i] && mask[i];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_wakeup_enable <= 1'b0;
      voltage_detector_enable <= 1'b0;
      noise_reject_option <= 1'b0;
      low_freq_crystal_mode <= 1'b0;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_idx == IDX_WAKEUP_CONTROL_2) begin
        conversion_wakeup_enable <= wr_data[WAKE_ADC_BIT];
      end
      if (wr_idx == IDX_CONTROL) begin
        voltage_detector_enable <= wr_data[CTL_DETECTOR_BIT];
        noise_reject_option <= wr_data[CTL_NOISE_BIT];
        low_freq_crystal_mode <= wr_data[CTL_LXT_BIT];
      end
    end
  end

  // Address and data are held independently so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI read path.
  // ************************************************************
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      status_reg[r] = REG_RESET;
      mask_reg[r] = REG_RESET;
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      status_reg[SRC_REG[i*2 +: 2]][SRC_BIT[i*3 +: 3]] = flag[i];
      mask_reg[SRC_REG[i*2 +: 2]][SRC_BIT[i*3 +: 3]] = mask[i];
    end
  end

  assign rd_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_byte = REG_RESET;
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_WAKEUP_CONTROL_2: rd_byte[WAKE_ADC_BIT] = conversion_wakeup_enable;
      IDX_CONTROL: begin
        rd_byte[CTL_DETECTOR_BIT] = voltage_detector_enable;
        rd_byte[CTL_NOISE_BIT] = noise_reject_option;
        rd_byte[CTL_LXT_BIT] = low_freq_crystal_mode;
        rd_byte[CTL_GIE_BIT] = gie;
      end
      IDX_STATUS_0: rd_byte = status_reg[0];
      IDX_INTERRUPT_STATUS_1: rd_byte = status_reg[1];
      IDX_STATUS_2: rd_byte = status_reg[2];
      IDX_MASK_0: rd_byte = mask_reg[0];
      IDX_INTERRUPT_MASK_1: rd_byte = mask_reg[1];
      IDX_MASK_2: rd_byte = mask_reg[2];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Global enable, priority and vectoring.
  // ************************************************************
  // Entry clears the enable so the handler is not re-entered before its flag is cleared.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie <= 1'b0;
    end else if (enable_interrupts_instr || return_from_interrupt_instr) begin
      gie <= 1'b1;
    end else if (disable_interrupts_instr || (svc == SVC_REQ && irq_accept)) begin
      gie <= 1'b0;
    end
  end

  // Scanning downward leaves the lowest index, which is the highest priority.
  always_comb begin
    any_pending = 1'b0;
    next_vector = VEC_RESET;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (enabled_pending[i]) begin
        any_pending = 1'b1;
        next_vector = (i == SRC_EXT) ? VEC_EXT_FETCH : SRC_VECTOR[i*VEC_W +: VEC_W];
      end
    end
  end

  always_comb begin
    next_svc = svc;
    case (svc)
      SVC_IDLE, SVC_BUSY: begin
        if (gie && any_pending) begin
          next_svc = SVC_REQ;
        end else if (svc == SVC_BUSY && return_from_interrupt_instr) begin
          next_svc = SVC_IDLE;
        end
      end
      SVC_REQ: begin
        if (irq_accept) begin
          next_svc = SVC_BUSY;
        end else if (!gie || !any_pending) begin
          next_svc = in_service ? SVC_BUSY : SVC_IDLE;
        end
      end
      default: next_svc = SVC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc <= SVC_IDLE;
      irq_request <= 1'b0;
      irq_vector <= VEC_RESET;
      in_service <= 1'b0;
    end else begin
      svc <= next_svc;
      irq_request <= (next_svc == SVC_REQ);
      if (next_svc == SVC_REQ) begin
        irq_vector <= next_vector;
      end
      if (svc == SVC_REQ && irq_accept) begin
        in_service <= 1'b1;
      end else if (return_from_interrupt_instr) begin
        in_service <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Context backup, wake-up and return stack.
  // ************************************************************
  // Only one backup exists, so a nested entry loses the outer context.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_saved <= '0;
      r3_saved <= '0;
      r4_saved <= '0;
      restore_strobe <= 1'b0;
    end else begin
      if (svc == SVC_REQ && irq_accept) begin
        acc_saved <= acc_in;
        r3_saved <= r3_in;
        r4_saved <= r4_in;
      end
      restore_strobe <= return_from_interrupt_instr && in_service;
    end
  end

  // Wake only; whether the vector follows is left to the global enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_core <= 1'b0;
    end else begin
      wake_core <= sleep_mode && flag[SRC_ADC] && mask[SRC_ADC] && conversion_wakeup_enable;
    end
  end

  generate
    for (genvar e = 0; e < STACK_DEPTH; e++) begin : g_stack
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stk[e] <= '0;
        end else if (stack_push) begin
          stk[e] <= (e == 0) ? push_addr : stk[(e == 0) ? 0 : e - 1];
        end else if (stack_pop) begin
          stk[e] <= (e == STACK_DEPTH - 1) ? '0 : stk[(e == STACK_DEPTH - 1) ? e : e + 1];
        end
      end
    end
  endgenerate

  assign stack_top = stk[0];

endmodule

//--- bench/mic_irq_monitor.sv
// Concurrent checks on the interrupt controller's core-side ports.
// Assumes it is bound into the controller and shares its clock and reset.
module mic_irq_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_request,
  input wire logic [mic_pkg::VEC_W-1:0] irq_vector,
  input wire logic irq_accept,
  input wire logic in_service,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] r3_in,
  input wire logic [DATA_W-1:0] r4_in,
  input wire logic [DATA_W-1:0] acc_saved,
  input wire logic [DATA_W-1:0] r3_saved,
  input wire logic [DATA_W-1:0] r4_saved,
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic restore_strobe,
  input wire logic sleep_mode,
  input wire logic wake_core,
  input wire logic [mic_pkg::VEC_W-1:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  import mic_pkg::*;
  // ************************************************************
  // Properties.
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_gie_off;
    disable_interrupts_instr && !enable_interrupts_instr && !return_from_interrupt_instr
      |=> ##1 !irq_request;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("request while disabled");
  property p_accept;
    irq_request && irq_accept |=> !irq_request && in_service ##1 !irq_request;
  endproperty
  a_accept: assert property (p_accept) else $error("accept did not enter service");
  property p_ctx;
    irq_request && irq_accept |=> acc_saved == $past(acc_in) && r3_saved == $past(r3_in)
      && r4_saved == $past(r4_in);
  endproperty
  a_ctx: assert property (p_ctx) else $error("context not saved");
  property p_return;
    in_service && return_from_interrupt_instr |=> restore_strobe && !in_service;
  endproperty
  a_return: assert property (p_return) else $error("return did not end service");
  property p_restore_cause;
    restore_strobe |-> $past(return_from_interrupt_instr) && $past(in_service);
  endproperty
  a_restore_cause: assert property (p_restore_cause) else $error("stray restore");
  property p_vec;
    irq_request |-> irq_vector inside {12'h003, 12'h004, 12'h006, 12'h008, 12'h00E, 12'h010,
      12'h012, 12'h014, 12'h016, 12'h01A, 12'h01C, 12'h01E, 12'h024, 12'h026, 12'h02A, 12'h02C};
  endproperty
  a_vec: assert property (p_vec) else $error("illegal vector");
  property p_wake;
    $rose(wake_core) |-> $past(sleep_mode);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_stack_clear;
    disable iff (1'b0) !aresetn |=> stack_top == 12'h000 && !irq_request;
  endproperty
  a_stack_clear: assert property (p_stack_clear) else $error("stack not cleared");
  c_accept: cover property (irq_request && irq_accept);
  c_ext: cover property (irq_request && irq_vector == 12'h003);
  c_restore: cover property (restore_strobe);
  c_wake: cover property (wake_core);
endmodule
bind mic_interrupt_controller mic_irq_monitor #(.DATA_W(DATA_W)) u_monitor (
  .aclk, .aresetn, .irq_request, .irq_vector, .irq_accept, .in_service, .acc_in, .r3_in,
  .r4_in, .acc_saved, .r3_saved, .r4_saved, .enable_interrupts_instr,
  .disable_interrupts_instr, .return_from_interrupt_instr, .restore_strobe, .sleep_mode,
  .wake_core, .stack_top
);

//--- bench/mic_core_model.sv
// Core fetch logic model: takes vector requests and offers a changing context.
// Assumes the controller's clock and synchronous reset.
module mic_core_model #(
  parameter int DATA_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_request,
  input wire logic slow,
  output logic irq_accept,
  output logic [DATA_W-1:0] acc_in,
  output logic [DATA_W-1:0] r3_in,
  output logic [DATA_W-1:0] r4_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Accept logic.
  // ************************************************************
  logic [DATA_W-1:0] ctx;
  logic [3:0] wait_cnt;
  // Context moves every cycle, so a save taken on the wrong edge shows up.
  assign acc_in = ctx;
  assign r3_in = ~ctx;
  assign r4_in = ctx ^ DATA_W'(8'h5A);
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctx <= '0;
      wait_cnt <= '0;
      irq_accept <= 1'b0;
    end else begin
      ctx <= ctx + 1'b1;
      irq_accept <= 1'b0;
      wait_cnt <= '0;
      if (irq_request && !irq_accept) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == (slow ? 4'h5 : 4'h0)) irq_accept <= 1'b1;
      end
    end
  end
endmodule

//--- bench/tb.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model answers vector requests; registers go over AXI4-Lite.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mic_pkg::*;
  // ************************************************************
  // Signals and tasks.
  // ************************************************************
  logic aclk = 0, aresetn = 0, slow = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_int_pin = 1, enable_interrupts_instr = 0, disable_interrupts_instr = 0;
  logic return_from_interrupt_instr = 0, sleep_mode = 0, stack_push = 0, stack_pop = 0;
  logic [15:1] src_event = 0;
  logic [11:0] push_addr = 0, irq_vector, stack_top;
  logic irq_accept, irq_request, in_service, restore_strobe, wake_core, s_axi_rvalid;
  logic [7:0] acc_in, r3_in, r4_in, acc_saved, r3_saved, r4_saved;
  int n_mismatch = 0, check_count = 0;
  logic [11:0] vt [16] = '{12'h003, 12'h004, 12'h006, 12'h008, 12'h00E, 12'h010, 12'h012,
    12'h014, 12'h016, 12'h01A, 12'h01C, 12'h01E, 12'h024, 12'h026, 12'h02A, 12'h02C};
  logic [5:0] rz [8] = '{IDX_WAKEUP_CONTROL_2, IDX_CONTROL, IDX_STATUS_0,
    IDX_INTERRUPT_STATUS_1, IDX_STATUS_2, IDX_MASK_0, IDX_INTERRUPT_MASK_1, IDX_MASK_2};
  always #50 aclk = ~aclk;
  mic_interrupt_controller dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_int_pin, .src_event,
    .enable_interrupts_instr, .disable_interrupts_instr, .return_from_interrupt_instr,
    .sleep_mode, .irq_accept, .acc_in, .r3_in, .r4_in, .stack_push, .stack_pop, .push_addr,
    .irq_request, .irq_vector, .in_service, .acc_saved, .r3_saved, .r4_saved,
    .restore_strobe, .wake_core, .stack_top);
  mic_core_model core (.aclk, .aresetn, .irq_request, .slow, .irq_accept, .acc_in, .r3_in,
    .r4_in);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, {24'h0, ed});
    check(s_axi_rresp, er);
  endtask
  task automatic ins(input int k);
    @(posedge aclk);
    enable_interrupts_instr <= (k == 0);
    disable_interrupts_instr <= (k == 1);
    return_from_interrupt_instr <= (k == 2);
    @(posedge aclk);
    enable_interrupts_instr <= 1'b0;
    disable_interrupts_instr <= 1'b0;
    return_from_interrupt_instr <= 1'b0;
  endtask
  task automatic evt(input logic [15:1] m);
    @(posedge aclk);
    src_event <= m;
    @(posedge aclk);
    src_event <= '0;
  endtask
  task automatic pin(input int n);
    @(posedge aclk);
    ext_int_pin <= 1'b0;
    tick(n);
    ext_int_pin <= 1'b1;
  endtask
  task automatic hold(input int k);
    int t;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (!(k == 1 ? in_service : k == 2 ? wake_core : irq_request) && t < 30);
  endtask
  // Clearing the flag before the return keeps the request from firing again.
  task automatic serve(input logic [11:0] v, input logic [5:0] ci);
    hold(0);
    check(irq_vector, v);
    hold(1);
    check(in_service, 1'b1);
    wr(ci, 8'h00, RESP_OKAY);
    ins(2);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ************************************************************
  // Tests.
  // ************************************************************
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    tick(10);
    aresetn <= 1'b1;
    check(stack_top, 12'h000);
    foreach (rz[j]) rd(rz[j], REG_RESET, RESP_OKAY);
    rd(6'h3F, 8'h00, RESP_SLVERR);
    wr(6'h3F, 8'hFF, RESP_SLVERR);
    evt(15'h0003);
    rd(IDX_STATUS_0, 8'h04, RESP_OKAY);
    wr(IDX_STATUS_0, 8'h00, RESP_OKAY);
    for (int r = 0; r < 3; r++) wr(6'(IDX_INTERRUPT_MASK_1 + r), 8'hFF, RESP_OKAY);
    rd(IDX_INTERRUPT_MASK_1, 8'h17, RESP_OKAY);
    ins(0);
    evt(15'h0004);
    tick(10);
    check(irq_request, 1'b0);
    wr(IDX_CONTROL, 8'h01, RESP_OKAY);
    serve(12'h008, IDX_STATUS_0);
    rd(IDX_CONTROL, 8'h81, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      slow <= i[0];
      if (i == 0) pin(8);
      else evt(15'(1) << (i - 1));
      serve(vt[i], 6'(IDX_STATUS_0 + SRC_REG[2*i +: 2]));
    end
    evt(15'h0810);
    serve(12'h010, IDX_INTERRUPT_STATUS_1);
    serve(12'h024, IDX_STATUS_2);
    ins(1);
    pin(3);
    tick(12);
    rd(IDX_STATUS_0, 8'h00, RESP_OKAY);
    wr(IDX_CONTROL, 8'h05, RESP_OKAY);
    pin(2);
    tick(6);
    rd(IDX_STATUS_0, 8'h01, RESP_OKAY);
    wr(IDX_STATUS_0, 8'h00, RESP_OKAY);
    wr(IDX_WAKEUP_CONTROL_2, 8'h10, RESP_OKAY);
    sleep_mode <= 1'b1;
    evt(15'h0010);
    hold(2);
    check(wake_core, 1'b1);
    check(irq_request, 1'b0);
    rd(IDX_INTERRUPT_STATUS_1, 8'h10, RESP_OKAY);
    ins(0);
    serve(12'h010, IDX_INTERRUPT_STATUS_1);
    sleep_mode <= 1'b0;
    stack_push <= 1'b1;
    push_addr <= 12'h5A3;
    @(posedge aclk);
    push_addr <= 12'hA5C;
    @(posedge aclk);
    stack_push <= 1'b0;
    stack_pop <= 1'b1;
    @(posedge aclk);
    stack_pop <= 1'b0;
    @(posedge aclk);
    check(stack_top, 12'h5A3);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    check(stack_top, 12'h000);
    rd(IDX_MASK_0, 8'h00, RESP_OKAY);
    tally_and_finish();
  end
endmodule
